// ### hw/sfcd_decoder.sv
// serial flash command decoder: opcode table, config registers, register reads/writes
// Functional notes
// [RQ1] 0Eh: dtr read, 4 addr bytes, dummy 6 single/dual, 8 quad, unlimited data
// [RQ2] BEh: dtr read 1-2-2, 4 addr bytes, dummy 6
// [RQ3] EEh: dtr read 1-4-4 or 4-4-4, 4 addr bytes, dummy 8
// [RQ4] 6Ch: read 1-1-4, 4 addr bytes, dummy 8 extended, 10 quad
// [RQ5] 70h: flag status byte repeated while the frame lasts
// [RQ6] B1h writes nonvolatile config with exactly two bytes; B5h reads at least two
// [RQ7] 85h reads volatile config repeatedly; 81h writes it with one byte
// [RQ8] 65h reads enhanced volatile config; 61h writes it with one byte
// [RQ9] C8h reads extended address register; C5h writes it with one byte
// [RQ10] 96h reads general purpose register after 8 dummy clocks, any protocol
// [RQ11] 50h clears flag status, opcode only
// [RQ12] A2h programs 1 to 256 bytes, 1-1-2, no dummy
// [RQ13] D2h programs up to 256 bytes, 1-2-2 or 2-2-2, no dummy
// [RQ14] 32h programs up to 256 bytes, 1-1-4, no dummy
// [RQ15] 38h programs up to 256 bytes, 1-4-4 or 4-4-4, no dummy
// [RQ16] 12h programs 1 to 256 bytes, always 4 addr bytes, all protocols
// [RQ17] 34h programs up to 256 bytes, 4 addr bytes, 1-1-4
// [RQ18] 3Eh programs up to 256 bytes, 4 addr bytes, 1-4-4
// [RQ19] 21h erases 4KB subsector, 4 addr bytes, no dummy or data
// [RQ20] DCh erases sector, always 4 addr bytes, no dummy or data
// [RQ21] host issues write enable first; otherwise modify commands are ignored
// [RQ22] 3(4)-byte commands take 4 bytes in 4-byte mode, else 3
// [RQ23] general purpose register is 64 bytes, then 00h without wrapping
// [RQ24] opcode on 1, 2 or 4 lines per protocol; address/data may widen
// [RQ25] 06h write enable, 04h write disable, opcode only
// [RQ26] 05h repeatable status read; 01h one-byte status write
// [RQ27] 02h page program; 52h, 20h, D8h erases; C7h/60h whole-array erase
// [RQ28] adjustable dummy count comes from config, table value as default
`default_nettype none
module sfcd_decoder
  import sfcd_pkg::*;
(
  input  wire logic                 i_core_clk,
  input  wire logic                 i_rst_n,
  input  wire sfcd_pkg::sfcd_proto_e i_proto,
  input  wire logic                 i_addr4,
  input  wire logic                 i_busy,
  input  wire logic                 i_op_valid,
  input  wire logic [7:0]           i_opcode,
  input  wire logic                 i_wr_valid,
  input  wire logic [7:0]           i_wr_byte,
  input  wire logic                 i_rd_req,
  input  wire logic                 i_frame_end,
  input  wire logic [7:0]           i_gprr_data,
  input  wire logic [7:0]           i_flag_set,
  output logic                      o_desc_valid,
  output sfcd_pkg::sfcd_desc_s      o_desc,
  output logic                      o_rd_valid,
  output logic [7:0]                o_rd_data,
  output logic [5:0]                o_gprr_idx,
  output logic                      o_op_start,
  output logic [7:0]                o_op_code,
  output logic [8:0]                o_op_bytes,
  output logic                      o_refused,
  output logic                      o_wel,
  output logic [7:0]                o_sr,
  output logic [7:0]                o_fsr,
  output logic [15:0]               o_nvcr,
  output logic [7:0]                o_vcr,
  output logic [7:0]                o_evcr,
  output logic [7:0]                o_ear
);
  import sfcd_pkg::*;

  typedef struct packed {
    sfcd_state_e st;
    logic        dvalid;
    sfcd_desc_s  desc;
    logic [7:0]  op;
    logic [8:0]  wcnt;
    logic        wover;
    logic [15:0] wbuf;
    logic [6:0]  rcnt;
    logic        rd_valid;
    logic [7:0]  rd_data;
    logic [5:0]  gidx;
    logic        op_start;
    logic [7:0]  op_code;
    logic [8:0]  op_bytes;
    logic        refused;
    logic        wel;
    logic [7:0]  sr;
    logic [7:0]  fsr;
    logic [15:0] nvcr;
    logic [7:0]  vcr;
    logic [7:0]  evcr;
    logic [7:0]  ear;
  } sfcd_state_s;

  sfcd_state_s r;
  sfcd_state_s next_r;
  logic [1:0]  rst_sync;
  logic        rst_n;

  //////////////////////////////////////////////////////////////////////////////
  // opcode table
  function automatic sfcd_desc_s sfcd_decode(input logic [7:0] op, input sfcd_proto_e pr,
                                             input logic a4, input logic [3:0] dcfg);
    sfcd_desc_s d;
    logic [2:0] ea;
    logic [2:0] ed;
    logic       okd;
    logic       okq;
    logic       adj;
    logic [4:0] dx;
    logic [4:0] dd;
    logic [4:0] dq;
    d = '0;
    d.known = 1'b1;
    d.kind = SFCD_K_NONE;
    d.regsel = SFCD_R_SR;
    ea = SFCD_L1;
    ed = SFCD_L1;
    okd = 1'b1;
    okq = 1'b1;
    adj = 1'b0;
    dx = 5'h00;
    dd = 5'h00;
    dq = 5'h00;
    case (op)
      8'h0e: begin d.kind = SFCD_K_READ; d.addr_bytes = SFCD_AB4;  // RQ1
        dx = SFCD_DUM6; dd = SFCD_DUM6; dq = SFCD_DUM8; adj = 1'b1; end
      8'hbe: begin d.kind = SFCD_K_READ; d.addr_bytes = SFCD_AB4;  // RQ2
        ea = SFCD_L2; ed = SFCD_L2; okq = 1'b0; dx = SFCD_DUM6; dd = SFCD_DUM6; adj = 1'b1; end
      8'hee: begin d.kind = SFCD_K_READ; d.addr_bytes = SFCD_AB4;  // RQ3
        ea = SFCD_L4; ed = SFCD_L4; okd = 1'b0; dx = SFCD_DUM8; dq = SFCD_DUM8; adj = 1'b1; end
      8'h6c: begin d.kind = SFCD_K_READ; d.addr_bytes = SFCD_AB4;  // RQ4
        ed = SFCD_L4; okd = 1'b0; dx = SFCD_DUM8; dq = SFCD_DUM10; adj = 1'b1; end
      8'hbc: begin d.kind = SFCD_K_READ; d.addr_bytes = SFCD_AB4;
        ea = SFCD_L2; ed = SFCD_L2; okq = 1'b0; dx = SFCD_DUM8; dd = SFCD_DUM8; adj = 1'b1; end
      8'hec: begin d.kind = SFCD_K_READ; d.addr_bytes = SFCD_AB4;
        ea = SFCD_L4; ed = SFCD_L4; okd = 1'b0; dx = SFCD_DUM10; dq = SFCD_DUM10; adj = 1'b1; end
      8'h06: d.kind = SFCD_K_WREN;  // RQ25
      8'h04: d.kind = SFCD_K_WRDI;  // RQ25
      8'h05: begin d.kind = SFCD_K_RREG; d.regsel = SFCD_R_SR; end  // RQ26
      8'h70: begin d.kind = SFCD_K_RREG; d.regsel = SFCD_R_FSR; end  // RQ5
      8'hb5: begin d.kind = SFCD_K_RREG; d.regsel = SFCD_R_NVCR;  // RQ6
        d.min_bytes = SFCD_TWO_BYTES; end
      8'h85: begin d.kind = SFCD_K_RREG; d.regsel = SFCD_R_VCR; end  // RQ7
      8'h65: begin d.kind = SFCD_K_RREG; d.regsel = SFCD_R_EVCR; end  // RQ8
      8'hc8: begin d.kind = SFCD_K_RREG; d.regsel = SFCD_R_EAR; end  // RQ9
      8'h96: begin d.kind = SFCD_K_RREG; d.regsel = SFCD_R_GPRR;  // RQ10
        dx = SFCD_DUM8; dd = SFCD_DUM8; dq = SFCD_DUM8; end
      8'h01: begin d.kind = SFCD_K_WREG; d.regsel = SFCD_R_SR; end  // RQ26
      8'hb1: begin d.kind = SFCD_K_WREG; d.regsel = SFCD_R_NVCR;  // RQ6
        d.min_bytes = SFCD_TWO_BYTES; d.max_bytes = SFCD_TWO_BYTES; end
      8'h81: begin d.kind = SFCD_K_WREG; d.regsel = SFCD_R_VCR; end  // RQ7
      8'h61: begin d.kind = SFCD_K_WREG; d.regsel = SFCD_R_EVCR; end  // RQ8
      8'hc5: begin d.kind = SFCD_K_WREG; d.regsel = SFCD_R_EAR; end  // RQ9
      8'h50: d.kind = SFCD_K_CLRF;  // RQ11
      8'h02: begin d.kind = SFCD_K_PROG; d.addr_bytes = a4 ? SFCD_AB4 : SFCD_AB3; end  // RQ27
      8'ha2: begin d.kind = SFCD_K_PROG; d.addr_bytes = a4 ? SFCD_AB4 : SFCD_AB3;  // RQ12
        ed = SFCD_L2; okq = 1'b0; end
      8'hd2: begin d.kind = SFCD_K_PROG; d.addr_bytes = a4 ? SFCD_AB4 : SFCD_AB3;  // RQ13
        ea = SFCD_L2; ed = SFCD_L2; okq = 1'b0; end
      8'h32: begin d.kind = SFCD_K_PROG; d.addr_bytes = a4 ? SFCD_AB4 : SFCD_AB3;  // RQ14
        ed = SFCD_L4; okd = 1'b0; end
      8'h38: begin d.kind = SFCD_K_PROG; d.addr_bytes = a4 ? SFCD_AB4 : SFCD_AB3;  // RQ15
        ea = SFCD_L4; ed = SFCD_L4; okd = 1'b0; end
      8'h12: begin d.kind = SFCD_K_PROG; d.addr_bytes = SFCD_AB4; end  // RQ16
      8'h34: begin d.kind = SFCD_K_PROG; d.addr_bytes = SFCD_AB4;  // RQ17
        ed = SFCD_L4; okd = 1'b0; end
      8'h3e: begin d.kind = SFCD_K_PROG; d.addr_bytes = SFCD_AB4;  // RQ18
        ea = SFCD_L4; ed = SFCD_L4; okd = 1'b0; end
      8'h52, 8'h20, 8'hd8: begin d.kind = SFCD_K_ERASE;  // RQ27 RQ22
        d.addr_bytes = a4 ? SFCD_AB4 : SFCD_AB3; end
      8'h21: begin d.kind = SFCD_K_ERASE; d.addr_bytes = SFCD_AB4; end  // RQ19
      8'hdc: begin d.kind = SFCD_K_ERASE; d.addr_bytes = SFCD_AB4; end  // RQ20
      8'hc7, 8'h60: d.kind = SFCD_K_ERASE;  // RQ27
      default: d.known = 1'b0;
    endcase
    // one-byte register writes share a single limit
    if (d.kind == SFCD_K_WREG && d.regsel != SFCD_R_NVCR) begin
      d.min_bytes = SFCD_ONE_BYTE;
      d.max_bytes = SFCD_ONE_BYTE;
    end
    if (d.kind == SFCD_K_PROG) begin
      d.min_bytes = SFCD_ONE_BYTE;
      d.max_bytes = SFCD_PAGE_BYTES;
    end
    if (d.kind == SFCD_K_READ || d.kind == SFCD_K_RREG) begin
      d.unlimited = 1'b1;
      if (d.min_bytes == 9'h000) begin
        d.min_bytes = SFCD_ONE_BYTE;
      end
    end
    d.needs_wel = (d.kind == SFCD_K_PROG) || (d.kind == SFCD_K_ERASE) ||
                  (d.kind == SFCD_K_WREG);  // RQ21
    // opcode width follows the protocol; dual/quad force all phases wide
    case (pr)  // RQ24
      SFCD_PROTO_DUAL: begin
        d.cmd_lines = SFCD_L2; ea = SFCD_L2; ed = SFCD_L2; d.dummy = dd;
        d.known = d.known & okd;
      end
      SFCD_PROTO_QUAD: begin
        d.cmd_lines = SFCD_L4; ea = SFCD_L4; ed = SFCD_L4; d.dummy = dq;
        d.known = d.known & okq;
      end
      default: begin
        d.cmd_lines = SFCD_L1; d.dummy = dx;
      end
    endcase
    if (adj && dcfg != SFCD_DCFG_DEF0 && dcfg != SFCD_DCFG_DEF1) begin
      d.dummy = {1'b0, dcfg};  // RQ28
    end
    d.addr_lines = (d.addr_bytes != 3'h0) ? ea : SFCD_L0;
    d.data_lines = (d.max_bytes != 9'h000 || d.unlimited) ? ed : SFCD_L0;
    if (!d.known) begin
      d.kind = SFCD_K_NONE;
    end
    return d;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // reset release
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  //////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic       commit;
    logic [7:0] rbyte;
    commit = 1'b0;
    rbyte = SFCD_ZERO_BYTE;
    next_r = r;
    next_r.rd_valid = 1'b0;
    next_r.op_start = 1'b0;
    next_r.refused = 1'b0;

    case (r.st)
      SFCD_ST_IDLE: begin
        if (i_op_valid) begin
          // vcr dummy field is taken at opcode time, not mid-frame
          next_r.desc = sfcd_decode(i_opcode, i_proto, i_addr4, r.vcr[7:4]);
          next_r.op = i_opcode;
          next_r.dvalid = 1'b1;
          next_r.wcnt = 9'h000;
          next_r.wover = 1'b0;
          next_r.rcnt = 7'h00;
          next_r.gidx = 6'h00;
          next_r.st = SFCD_ST_FRAME;
        end
      end
      SFCD_ST_FRAME: begin
        if (i_wr_valid) begin
          if (r.wcnt == SFCD_PAGE_BYTES) begin
            next_r.wover = 1'b1;
          end else begin
            next_r.wcnt = r.wcnt + 9'h001;
          end
          if (r.wcnt < SFCD_TWO_BYTES) begin
            next_r.wbuf = {i_wr_byte, r.wbuf[15:8]};
          end
        end
        if (i_rd_req && r.desc.kind == SFCD_K_RREG) begin
          case (r.desc.regsel)
            SFCD_R_SR:   rbyte = {r.sr[7:2], r.wel, i_busy};  // RQ26
            SFCD_R_FSR:  rbyte = r.fsr;  // RQ5
            SFCD_R_NVCR: rbyte = r.rcnt[0] ? r.nvcr[15:8] : r.nvcr[7:0];  // RQ6
            SFCD_R_VCR:  rbyte = r.vcr;  // RQ7
            SFCD_R_EVCR: rbyte = r.evcr;  // RQ8
            SFCD_R_EAR:  rbyte = r.ear;  // RQ9
            SFCD_R_GPRR: rbyte = (r.rcnt < SFCD_GPRR_BYTES) ? i_gprr_data
                                                            : SFCD_ZERO_BYTE;  // RQ23
            default:     rbyte = SFCD_ZERO_BYTE;
          endcase
          next_r.rd_valid = 1'b1;
          next_r.rd_data = rbyte;
          // saturate at 64 so the zero fill never wraps back to byte 0
          if (r.rcnt != SFCD_GPRR_BYTES) begin
            next_r.rcnt = r.rcnt + 7'h01;  // RQ23
          end
          next_r.gidx = (r.rcnt + 7'h01 < SFCD_GPRR_BYTES) ? 6'(r.rcnt + 7'h01) : 6'h3f;
        end
        if (i_frame_end) begin
          next_r.st = SFCD_ST_IDLE;
          next_r.dvalid = 1'b0;
          case (r.desc.kind)
            SFCD_K_WREN: next_r.wel = 1'b1;  // RQ25
            SFCD_K_WRDI: next_r.wel = 1'b0;  // RQ25
            SFCD_K_PROG, SFCD_K_ERASE, SFCD_K_WREG: begin
              commit = r.wel && !r.wover && r.wcnt >= r.desc.min_bytes &&
                       r.wcnt <= r.desc.max_bytes;  // RQ21
              next_r.refused = !commit;
              if (commit) begin
                next_r.wel = 1'b0;
                next_r.op_start = (r.desc.kind != SFCD_K_WREG);
                next_r.op_code = r.op;
                next_r.op_bytes = r.wcnt;
              end
            end
            default: commit = 1'b0;
          endcase
          if (commit && r.desc.kind == SFCD_K_WREG) begin
            case (r.desc.regsel)
              SFCD_R_SR:   next_r.sr = r.wbuf[15:8];  // RQ26
              SFCD_R_NVCR: next_r.nvcr = r.wbuf;  // RQ6
              SFCD_R_VCR:  next_r.vcr = r.wbuf[15:8];  // RQ7
              SFCD_R_EVCR: next_r.evcr = r.wbuf[15:8];  // RQ8
              SFCD_R_EAR:  next_r.ear = r.wbuf[15:8];  // RQ9
              default:     next_r.ear = r.ear;
            endcase
          end
          if (r.desc.kind == SFCD_K_NONE) begin
            next_r.refused = 1'b1;
          end
        end
      end
      default: next_r.st = SFCD_ST_IDLE;
    endcase

    // a flag raised in the clearing cycle survives the clear
    if (r.st == SFCD_ST_FRAME && i_frame_end && r.desc.kind == SFCD_K_CLRF) begin
      next_r.fsr = SFCD_FSR_RST | i_flag_set;  // RQ11
    end else begin
      next_r.fsr = r.fsr | i_flag_set;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.st <= SFCD_ST_IDLE;
      r.desc.kind <= SFCD_K_NONE;
      r.desc.regsel <= SFCD_R_SR;
      r.sr <= SFCD_SR_RST;
      r.fsr <= SFCD_FSR_RST;
      r.nvcr <= SFCD_NVCR_RST;
      r.vcr <= SFCD_VCR_RST;
      r.evcr <= SFCD_EVCR_RST;
      r.ear <= SFCD_EAR_RST;
    end else begin
      r <= next_r;
    end
  end

  assign o_desc_valid = r.dvalid;
  assign o_desc = r.desc;
  assign o_rd_valid = r.rd_valid;
  assign o_rd_data = r.rd_data;
  assign o_gprr_idx = r.gidx;
  assign o_op_start = r.op_start;
  assign o_op_code = r.op_code;
  assign o_op_bytes = r.op_bytes;
  assign o_refused = r.refused;
  assign o_wel = r.wel;
  assign o_sr = r.sr;
  assign o_fsr = r.fsr;
  assign o_nvcr = r.nvcr;
  assign o_vcr = r.vcr;
  assign o_evcr = r.evcr;
  assign o_ear = r.ear;

endmodule // sfcd_decoder
`default_nettype wire

// ### common/sfcd_pkg.sv
// constants and types shared by the serial flash command decoder
`default_nettype none
package sfcd_pkg;

  typedef enum logic [2:0] {
    SFCD_PROTO_EXT  = 3'b001,
    SFCD_PROTO_DUAL = 3'b010,
    SFCD_PROTO_QUAD = 3'b100
  } sfcd_proto_e;

  typedef enum logic [8:0] {
    SFCD_K_NONE  = 9'b000000001,
    SFCD_K_READ  = 9'b000000010,
    SFCD_K_PROG  = 9'b000000100,
    SFCD_K_ERASE = 9'b000001000,
    SFCD_K_RREG  = 9'b000010000,
    SFCD_K_WREG  = 9'b000100000,
    SFCD_K_WREN  = 9'b001000000,
    SFCD_K_WRDI  = 9'b010000000,
    SFCD_K_CLRF  = 9'b100000000
  } sfcd_kind_e;

  typedef enum logic [6:0] {
    SFCD_R_SR   = 7'b0000001,
    SFCD_R_FSR  = 7'b0000010,
    SFCD_R_NVCR = 7'b0000100,
    SFCD_R_VCR  = 7'b0001000,
    SFCD_R_EVCR = 7'b0010000,
    SFCD_R_EAR  = 7'b0100000,
    SFCD_R_GPRR = 7'b1000000
  } sfcd_reg_e;

  typedef enum logic [1:0] {
    SFCD_ST_IDLE  = 2'b01,
    SFCD_ST_FRAME = 2'b10
  } sfcd_state_e;

  // one decoded command; line counts are 0, 1, 2 or 4
  typedef struct packed {
    logic       known;
    sfcd_kind_e kind;
    sfcd_reg_e  regsel;
    logic [2:0] cmd_lines;
    logic [2:0] addr_lines;
    logic [2:0] data_lines;
    logic [2:0] addr_bytes;
    logic [4:0] dummy;
    logic [8:0] min_bytes;
    logic [8:0] max_bytes;
    logic       unlimited;
    logic       needs_wel;
  } sfcd_desc_s;

  localparam logic [2:0] SFCD_L0 = 3'h0;
  localparam logic [2:0] SFCD_L1 = 3'h1;
  localparam logic [2:0] SFCD_L2 = 3'h2;
  localparam logic [2:0] SFCD_L4 = 3'h4;
  localparam logic [2:0] SFCD_AB3 = 3'h3;
  localparam logic [2:0] SFCD_AB4 = 3'h4;
  localparam logic [4:0] SFCD_DUM6 = 5'h06;
  localparam logic [4:0] SFCD_DUM8 = 5'h08;
  localparam logic [4:0] SFCD_DUM10 = 5'h0a;
  localparam logic [8:0] SFCD_PAGE_BYTES = 9'h100;
  localparam logic [8:0] SFCD_ONE_BYTE = 9'h001;
  localparam logic [8:0] SFCD_TWO_BYTES = 9'h002;
  localparam logic [6:0] SFCD_GPRR_BYTES = 7'h40;
  localparam logic [7:0] SFCD_ZERO_BYTE = 8'h00;
  localparam logic [3:0] SFCD_DCFG_DEF0 = 4'h0;
  localparam logic [3:0] SFCD_DCFG_DEF1 = 4'hf;

  localparam logic [7:0] SFCD_SR_RST = 8'h00;
  localparam logic [7:0] SFCD_FSR_RST = 8'h80;
  localparam logic [15:0] SFCD_NVCR_RST = 16'hffff;
  localparam logic [7:0] SFCD_VCR_RST = 8'hff;
  localparam logic [7:0] SFCD_EVCR_RST = 8'hff;
  localparam logic [7:0] SFCD_EAR_RST = 8'h00;
endpackage : sfcd_pkg
`default_nettype wire

// ### test/sfcd_decoder_asserts.sv
// concurrent checks on the ports of the serial flash command decoder
`default_nettype none
module sfcd_decoder_asserts
  import sfcd_pkg::*;
(
  input  wire logic                 i_core_clk,
  input  wire logic                 i_rst_n,
  input  wire logic                 i_busy,
  input  wire logic                 i_op_valid,
  input  wire logic                 i_rd_req,
  input  wire logic                 i_frame_end,
  input  wire logic [7:0]           i_flag_set,
  input  wire logic                 o_desc_valid,
  input  wire sfcd_pkg::sfcd_desc_s o_desc,
  input  wire logic                 o_rd_valid,
  input  wire logic [7:0]           o_rd_data,
  input  wire logic [7:0]           o_fsr,
  input  wire logic                 o_op_start,
  input  wire logic                 o_refused,
  input  wire logic                 o_wel
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  ////////////////////////////////////////////////////////////////////////////////
  desc_after_op_a: assert property (i_op_valid && !o_desc_valid |=> o_desc_valid)
    else $error("descriptor missing after opcode");
  desc_drop_a: assert property (o_desc_valid && i_frame_end |=> !o_desc_valid)
    else $error("descriptor outlived its frame");
  desc_hold_a: assert property (o_desc_valid && $past(o_desc_valid) |-> $stable(o_desc))
    else $error("descriptor changed inside a frame");
  rd_answer_a: assert property (o_rd_valid |-> $past(i_rd_req) && $past(o_desc_valid))
    else $error("read byte without a request");
  fsr_read_a: assert property (o_rd_valid && o_desc.kind == SFCD_K_RREG &&
    o_desc.regsel == SFCD_R_FSR |-> o_rd_data == $past(o_fsr))
    else $error("flag status byte differs from register");
  status_read_a: assert property (o_rd_valid && o_desc.kind == SFCD_K_RREG &&
    o_desc.regsel == SFCD_R_SR |-> o_rd_data[1:0] == {$past(o_wel), $past(i_busy)})
    else $error("status byte low bits wrong");
  start_wel_a: assert property (o_op_start |-> $past(o_wel) && !o_wel && $past(i_frame_end))
    else $error("operation started without write enable");
  refuse_keep_a: assert property (o_refused |-> !o_op_start && o_wel == $past(o_wel))
    else $error("refusal changed write enable");
  wel_edge_a: assert property ($changed(o_wel) |-> $past(i_frame_end))
    else $error("write enable moved inside a frame");
  clr_flag_a: assert property (o_desc_valid && o_desc.kind == SFCD_K_CLRF && i_frame_end &&
    i_flag_set == 8'h00 |=> o_fsr == 8'h80)
    else $error("flag status not cleared");
endmodule // sfcd_decoder_asserts
`default_nettype wire

// ### test/sfcd_host_model.sv
// host controller model: strobes opcode, data and read requests into the decoder
`default_nettype none
module sfcd_host_model
  import sfcd_pkg::*;
(
  input  wire logic                  i_core_clk,
  output var logic                   o_op_valid,
  output var logic [7:0]             o_opcode,
  output var sfcd_pkg::sfcd_proto_e  o_proto,
  output var logic                   o_addr4,
  output var logic                   o_wr_valid,
  output var logic [7:0]             o_wr_byte,
  output var logic                   o_rd_req,
  output var logic                   o_frame_end
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {o_op_valid, o_wr_valid, o_rd_req, o_frame_end} = 4'h0;
    o_opcode = 8'h00;
    o_wr_byte = 8'h00;
    o_proto = SFCD_PROTO_EXT;
    o_addr4 = 1'b0;
  end
  // one strobe per call, always a free edge between calls
  task automatic strobe(input int which, input logic [7:0] b, input sfcd_proto_e pr,
                        input logic a4);
    @(posedge i_core_clk);
    case (which)
      0: o_op_valid <= 1'b1;
      1: o_wr_valid <= 1'b1;
      2: o_rd_req <= 1'b1;
      default: o_frame_end <= 1'b1;
    endcase
    o_opcode <= b;
    o_wr_byte <= b;
    o_proto <= pr;
    o_addr4 <= a4;
    @(posedge i_core_clk);
    {o_op_valid, o_wr_valid, o_rd_req, o_frame_end} <= 4'h0;
    // unqualified lines carry the inverse so a stale byte never matches
    o_opcode <= ~b;
    o_wr_byte <= ~b;
  endtask
endmodule // sfcd_host_model
`default_nettype wire

// ### test/tb.sv
// self-checking bench for the serial flash command decoder
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sfcd_pkg::*;
  logic        i_core_clk, i_rst_n, i_busy, i_op_valid, i_addr4, i_wr_valid, i_rd_req;
  logic        i_frame_end, o_desc_valid, o_rd_valid, o_op_start, o_refused, o_wel, a4;
  logic [7:0]  i_flag_set, i_gprr_data, i_opcode, i_wr_byte, o_rd_data, o_op_code, v;
  logic [7:0]  o_sr, o_fsr, o_vcr, o_evcr, o_ear, lfsr_q, wbuf [2];
  sfcd_proto_e i_proto, pr;
  sfcd_desc_s  o_desc;
  logic [5:0]  o_gprr_idx;
  logic [8:0]  o_op_bytes, rd_q [$];
  logic [15:0] o_nvcr;
  logic [16:0] got;
  logic [17:0] st_q [$];
  logic [23:0] p;
  logic [43:0] r;
  int          err_total, checks, n_ref, n0;
  logic [43:0] tbl [40] = '{
    44'h0e101111406, 44'h0e401444408, 44'hbe101122406, 44'hee401444408,
    44'h6c101114408, 44'h6c40144440a, 44'h70104101000, 44'hb5204202000,
    44'hb1105101000, 44'h85104101000, 44'h81405404000, 44'h65104101000,
    44'h61205202000, 44'hc8104101000, 44'hc5105101000, 44'h96204202008,
    44'h50108100000, 44'ha2102112300, 44'hd2212222400, 44'h32102114300,
    44'h38402444300, 44'h12202222400, 44'h34102114400, 44'h3e102144400,
    44'h21103110400, 44'hdc403440400, 44'h06406400000, 44'h04207200000,
    44'h05104101000, 44'h01105101000, 44'h02112111400, 44'h52203220300,
    44'h20113110400, 44'hd8403440300, 44'hc7103100000, 44'h60203200000,
    44'h77100000000, 44'ha2400000000, 44'hbc101122408, 44'hec40144440a};
  // opcode, byte count, accepted
  logic [23:0] pe [6] = '{24'h021001, 24'h121010, 24'ha20011, 24'h210001, 24'h340000,
                          24'hdc0010};
  assign i_gprr_data = {2'h0, o_gprr_idx} ^ 8'h5a;
  sfcd_decoder sfcd_decoder_i (.*);
  sfcd_host_model sfcd_host_model_i (
    .i_core_clk(i_core_clk), .o_op_valid(i_op_valid), .o_opcode(i_opcode), .o_proto(i_proto),
    .o_addr4(i_addr4), .o_wr_valid(i_wr_valid), .o_wr_byte(i_wr_byte), .o_rd_req(i_rd_req),
    .o_frame_end(i_frame_end));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rnd(output logic [7:0] o);
    lfsr_q = {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
    o = lfsr_q;
  endtask
  task automatic st(input int w, input logic [7:0] b);
    sfcd_host_model_i.strobe(w, b, pr, a4);
  endtask
  task automatic frame_close();
    st(3, 8'h00);
    repeat (2) @(posedge i_core_clk);
    #1;
  endtask
  task automatic frame_open(input logic [7:0] code, input int n, input logic wren);
    logic [7:0] b;
    if (wren) begin
      st(0, 8'h06);
      frame_close();
    end
    st(0, code);
    for (int k = 0; k < n; k++) begin
      b = wbuf[k % 2];
      if (k > 1) rnd(b);
      st(1, b);
    end
  endtask
  task automatic rd(input logic [7:0] e);
    rd_q.push_back({1'b0, e});
    st(2, 8'h00);
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // results are compared in arrival order; an empty queue never matches
  always @(posedge i_core_clk) begin
    if (o_rd_valid === 1'b1) chk({1'b0, o_rd_data}, rd_q.size() ? rd_q.pop_front() : 9'h100);
    if (o_op_start === 1'b1) chk({1'b0, o_op_code, o_op_bytes}, st_q.size() ? st_q.pop_front() : 18'h20000);
    if (o_refused === 1'b1) n_ref++;
  end
  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end
  initial begin
    #900us;
    chk(32'h0, 32'h1);
    tally_and_finish();
  end
  initial begin
    {err_total, checks, n_ref} = '0;
    {i_rst_n, i_busy, a4, i_flag_set, lfsr_q} = {3'b010, 8'h00, 8'h15};
    pr = SFCD_PROTO_EXT;
    repeat (4) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_core_clk);
    #1;
    chk({o_sr, o_fsr, o_vcr, o_evcr}, 32'h0080ffff);
    chk({o_nvcr, o_ear, 7'h0, o_wel}, 32'hffff0000);
    foreach (tbl[i]) begin
      r = tbl[i];
      pr = sfcd_proto_e'(r[34:32]);
      a4 = r[28];
      frame_open(r[43:36], 0, 1'b0);
      @(posedge i_core_clk);
      #1;
      chk({o_desc.known, o_desc.kind}, {r[27:24] != 4'h0, 9'h1 << r[27:24]});
      got = {o_desc.cmd_lines, o_desc.addr_lines, o_desc.data_lines, o_desc.addr_bytes, o_desc.dummy};
      if (r[27:24] != 4'h0) chk(got, {r[22:20], r[18:16], r[14:12], r[10:8], r[4:0]});
      frame_close();
    end
    {pr, a4} = {SFCD_PROTO_EXT, 1'b0};
    rnd(v);
    wbuf[0] = v;
    frame_open(8'h81, 1, 1'b1);
    frame_close();
    chk({o_vcr, o_wel}, {v, 1'b0});
    n0 = n_ref;
    wbuf[0] = ~v;
    frame_open(8'h81, 1, 1'b0);
    frame_close();
    chk({o_vcr, 24'(n_ref - n0)}, {v, 24'h1});
    wbuf = '{8'h34, 8'h12};
    frame_open(8'hb1, 2, 1'b1);
    frame_close();
    chk(o_nvcr, 16'h1234);
    frame_open(8'hb1, 1, 1'b1);
    frame_close();
    chk({o_nvcr, o_wel}, {16'h1234, 1'b1});
    frame_open(8'h04, 0, 1'b0);
    frame_close();
    chk(o_wel, 1'b0);
    frame_open(8'hb5, 0, 1'b0);
    rd(8'h34);
    rd(8'h12);
    rd(8'h34);
    frame_close();
    frame_open(8'h85, 0, 1'b0);
    rd(v);
    rd(v);
    frame_close();
    frame_open(8'h05, 0, 1'b0);
    rd(8'h01);
    frame_close();
    wbuf[0] = 8'h3c;
    frame_open(8'hc5, 1, 1'b1);
    frame_close();
    frame_open(8'hc8, 0, 1'b0);
    rd(8'h3c);
    frame_close();
    rnd(v);
    @(posedge i_core_clk);
    i_flag_set <= v;
    @(posedge i_core_clk);
    i_flag_set <= 8'h00;
    frame_open(8'h70, 0, 1'b0);
    rd(8'h80 | v);
    rd(8'h80 | v);
    frame_close();
    frame_open(8'h50, 0, 1'b0);
    frame_close();
    chk(o_fsr, 8'h80);
    frame_open(8'h96, 0, 1'b0);
    for (int k = 0; k < 66; k++) rd(k < 64 ? 8'(k) ^ 8'h5a : 8'h00);
    frame_close();
    foreach (pe[i]) begin
      p = pe[i];
      n0 = n_ref;
      if (p[0]) st_q.push_back({1'b0, p[23:16], p[12:4]});
      frame_open(p[23:16], int'(p[15:4]), 1'b1);
      frame_close();
      chk({o_wel, 8'(n_ref - n0)}, {!p[0], 7'h0, !p[0]});
    end
    wbuf[0] = 8'h53;
    frame_open(8'h81, 1, 1'b1);
    frame_close();
    frame_open(8'h0e, 0, 1'b0);
    @(posedge i_core_clk);
    #1;
    chk(o_desc.dummy, 5'h05);
    frame_close();
    for (int k = 0; k < 20 && rd_q.size() + st_q.size() > 0; k++) @(posedge i_core_clk);
    if (rd_q.size() + st_q.size() > 0) chk(32'h0, 32'h1);
    tally_and_finish();
  end
endmodule // tb
bind sfcd_decoder sfcd_decoder_asserts sfcd_decoder_asserts_i (.*);
`default_nettype wire
